/* hdl/gdc_control.sv */
// Gauge discrete control: contact inputs, degas timer, status outputs, AXI4-Lite registers.
`timescale 1ns/100ps
module gdc_control #(
   parameter int unsigned SECOND_CYCLES = gdc_pkg::SECOND_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sensorOnPin_n,
   input wire logic degasPin_n,
   input wire logic emissionPin_n,
   input wire logic panelFilamentBtn_n,
   input wire logic panelEmissionBtn_n,
   input wire logic panelDegasBtn_n,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic filamentOn,
   output logic emission4mA,
   output logic degasOn,
   output logic degasStatusOc,
   output logic filamentStatusOc,
   output logic irq
);

   typedef struct packed {
      logic awHave;
      logic [7:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic swFil;
      logic swEmi;
      logic [3:0] degasMin;
      logic panelFil;
      logic panelEmi;
      logic filament;
      logic emission;
      logic degas;
      logic [31:0] tick;
      logic [9:0] secLeft;
      logic [2:0] irqStatus;
      logic [2:0] irqEnable;
      logic irq;
   } gdc_state_t;

   gdc_state_t s;
   gdc_state_t next_s;
   logic [gdc_pkg::IN_COUNT-1:0] pins_n;
   logic [gdc_pkg::IN_COUNT-1:0] gnd;
   logic [gdc_pkg::IN_COUNT-1:0] gndEdge;
   logic [gdc_pkg::IN_COUNT-1:0] relEdge;

   // ************************************************************
   // Input conditioning.
   // ************************************************************
   // Every contact, pin or panel button, goes through the same filter.
   assign pins_n = {panelDegasBtn_n, panelEmissionBtn_n, panelFilamentBtn_n,
                    emissionPin_n, degasPin_n, sensorOnPin_n};

   for (genvar i = 0; i < gdc_pkg::IN_COUNT; i++) begin : g_in
      gdc_input_filter u_filter (
         .clock(clock),
         .rst_n(rst_n),
         .pin_n(pins_n[i]),
         .grounded(gnd[i]),
         .groundEdge(gndEdge[i]),
         .releaseEdge(relEdge[i])
      ); // R10
   end

   // Read data for a register offset; unmapped offsets read zero.
   function automatic logic [31:0] read_word(input gdc_state_t st, input logic [7:0] a,
                                             input logic [5:0] g);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         gdc_pkg::OFS_CONTROL: begin
            d[gdc_pkg::CTRL_FIL_BIT] = st.swFil;
            d[gdc_pkg::CTRL_EMI_BIT] = st.swEmi;
            d[gdc_pkg::CTRL_MIN_LSB +: 4] = st.degasMin;
         end
         gdc_pkg::OFS_STATUS: begin
            d[gdc_pkg::STAT_FIL_BIT] = st.filament;
            d[gdc_pkg::STAT_DEG_BIT] = st.degas;
            d[gdc_pkg::STAT_EMI_BIT] = st.emission;
            d[gdc_pkg::STAT_PIN_LSB +: 6] = g;
            d[gdc_pkg::STAT_LEFT_LSB +: 10] = st.secLeft;
         end
         gdc_pkg::OFS_IRQ_STATUS: d[2:0] = st.irqStatus;
         gdc_pkg::OFS_IRQ_ENABLE: d[2:0] = st.irqEnable;
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction : read_word

   // True for offsets that answer OKAY on a read.
   function automatic logic read_mapped(input logic [7:0] a);
      return a == gdc_pkg::OFS_CONTROL || a == gdc_pkg::OFS_STATUS ||
             a == gdc_pkg::OFS_IRQ_STATUS || a == gdc_pkg::OFS_IRQ_ENABLE;
   endfunction : read_mapped

   // ************************************************************
   // Next state.
   // ************************************************************
   always_comb begin
      logic doWrite;
      logic swStart;
      logic swStop;
      logic [3:0] minutes;
      logic [2:0] irqClear;
      logic [2:0] events;
      logic startDegas;
      logic filBefore;
      next_s = s;
      doWrite = 1'b0;
      swStart = 1'b0;
      swStop = 1'b0;
      minutes = s.degasMin;
      irqClear = 3'h0;
      events = 3'h0;
      startDegas = 1'b0;
      filBefore = s.filament;

      // Address and data are caught independently, in either order.
      if (awvalid && s.awready) begin
         next_s.awHave = 1'b1;
         next_s.awAddr = {awaddr[7:2], 2'h0};
      end
      if (wvalid && s.wready) begin
         next_s.wHave = 1'b1;
         next_s.wData = wdata;
         next_s.wStrb = wstrb;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end

      // A write completes once both halves are held and the last response is gone.
      if (s.awHave && s.wHave && !s.bvalid) begin
         doWrite = 1'b1;
         next_s.awHave = 1'b0;
         next_s.wHave = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = gdc_pkg::RESP_OKAY;
         case (s.awAddr)
            gdc_pkg::OFS_CONTROL: begin
               if (s.wStrb[0]) begin
                  next_s.swFil = s.wData[gdc_pkg::CTRL_FIL_BIT]; // R9
                  next_s.swEmi = s.wData[gdc_pkg::CTRL_EMI_BIT]; // R9
                  swStart = s.wData[gdc_pkg::CTRL_DSTART_BIT];
                  swStop = s.wData[gdc_pkg::CTRL_DSTOP_BIT];
               end
               if (s.wStrb[1]) begin
                  minutes = s.wData[gdc_pkg::CTRL_MIN_LSB +: 4];
                  // Out-of-range settings are clamped so a cycle is never shorter or longer.
                  if (minutes < gdc_pkg::DEGAS_MIN_LO) begin
                     minutes = gdc_pkg::DEGAS_MIN_LO; // R4
                  end else if (minutes > gdc_pkg::DEGAS_MIN_HI) begin
                     minutes = gdc_pkg::DEGAS_MIN_HI; // R4
                  end
                  next_s.degasMin = minutes;
               end
            end
            gdc_pkg::OFS_IRQ_ENABLE: begin
               if (s.wStrb[0]) begin
                  next_s.irqEnable = s.wData[2:0];
               end
            end
            gdc_pkg::OFS_IRQ_CLEAR: begin
               if (s.wStrb[0]) begin
                  irqClear = s.wData[2:0];
               end
            end
            gdc_pkg::OFS_STATUS, gdc_pkg::OFS_IRQ_STATUS: begin
               next_s.bresp = gdc_pkg::RESP_OKAY;
            end
            default: begin
               next_s.bresp = gdc_pkg::RESP_SLVERR;
            end
         endcase
      end
      next_s.awready = ~next_s.awHave;
      next_s.wready = ~next_s.wHave;

      // Read channel: one read in flight, answered the cycle after the address is taken.
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      if (arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = read_word(s, {araddr[7:2], 2'h0}, gnd);
         next_s.rresp = read_mapped({araddr[7:2], 2'h0}) ? gdc_pkg::RESP_OKAY
                                                          : gdc_pkg::RESP_SLVERR;
      end
      next_s.arready = ~next_s.rvalid;

      // The filament and emission panel buttons toggle their own requests on each filtered press.
      if (gndEdge[gdc_pkg::IN_BTN_FIL]) begin
         next_s.panelFil = ~s.panelFil; // R9
      end
      if (gndEdge[gdc_pkg::IN_BTN_EMI]) begin
         next_s.panelEmi = ~s.panelEmi; // R9
      end

      // Releasing the sensor contact drops every filament request, so it always switches off.
      if (relEdge[gdc_pkg::IN_SENSOR]) begin
         next_s.swFil = 1'b0; // R2
         next_s.panelFil = 1'b0; // R2
      end
      next_s.filament = gnd[gdc_pkg::IN_SENSOR] | next_s.swFil | next_s.panelFil; // R1
      next_s.emission = gnd[gdc_pkg::IN_EMISSION] | next_s.swEmi | next_s.panelEmi; // R6

      // Only a filtered grounding edge or the software start bit starts degas; a held contact gives no new edge.
      startDegas = gndEdge[gdc_pkg::IN_DEGAS] | gndEdge[gdc_pkg::IN_BTN_DEG] | swStart; // R3 R5
      if (swStop && s.degas) begin
         next_s.degas = 1'b0;
         next_s.secLeft = 10'h000;
         next_s.tick = 32'h0000_0000;
         events[gdc_pkg::IRQ_DDONE_BIT] = 1'b1;
      end else if (!s.degas && startDegas) begin
         next_s.degas = 1'b1;
         next_s.tick = 32'h0000_0000;
         next_s.secLeft = 10'({6'h00, s.degasMin} * gdc_pkg::SECONDS_PER_MINUTE); // R4
         events[gdc_pkg::IRQ_DSTART_BIT] = 1'b1;
      end else if (s.degas) begin
         // The timer ignores the degas contact, so the cycle finishes after release.
         if (s.tick == 32'(SECOND_CYCLES - 1)) begin
            next_s.tick = 32'h0000_0000;
            next_s.secLeft = s.secLeft - 10'h001; // R4
            if (s.secLeft == 10'h001) begin
               next_s.degas = 1'b0; // R4
               events[gdc_pkg::IRQ_DDONE_BIT] = 1'b1;
            end
         end else begin
            next_s.tick = s.tick + 32'h0000_0001;
         end
      end
      events[gdc_pkg::IRQ_FIL_BIT] = next_s.filament ^ filBefore;

      // A new event outranks a clear arriving in the same cycle.
      next_s.irqStatus = (s.irqStatus & ~irqClear) | events;
      next_s.irq = |(next_s.irqStatus & next_s.irqEnable);
      if (doWrite) begin
         next_s.bvalid = 1'b1;
      end
   end

   // ************************************************************
   // State register.
   // ************************************************************
   // Power-up leaves filament, sensor and degas off until something asks for them.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0; // R11
         s.awready <= 1'b1;
         s.wready <= 1'b1;
         s.arready <= 1'b1;
         s.degasMin <= gdc_pkg::DEGAS_MIN_RST;
         s.irqEnable <= gdc_pkg::IRQ_ENABLE_RST;
      end else begin
         s <= next_s;
      end
   end

   // ************************************************************
   // Outputs, each straight from the state register.
   // ************************************************************
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign filamentOn = s.filament; // R1
   assign emission4mA = s.emission; // R6
   assign degasOn = s.degas;
   assign degasStatusOc = s.degas; // R7
   assign filamentStatusOc = s.filament; // R8
   assign irq = s.irq;

endmodule : gdc_control

/* hdl/gdc_pkg.sv */
// Package of constants for the gauge discrete control block.
// Contract
// (R1) Filament and sensor stay on while the sensor input is held grounded.
// (R2) Releasing the sensor input ground switches the filament off.
// (R3) A brief ground on the degas input starts a degas cycle.
// (R4) Degas runs for the set 2 to 10 minutes, even after release.
// (R5) Degas restarts only after release and a fresh ground; holding never retriggers.
// (R6) Grounded emission input selects 4 mA; open selects 100 uA.
// (R7) Degas status output is on exactly while degas is active.
// (R8) Filament status output is on exactly while the filament is on.
// (R9) Pins, serial commands and panel buttons all request filament, emission, degas.
// (R10) Inputs are synchronised and glitch filtered; degas starts on filtered grounding.
// (R11) After power up the filament is off and the sensor inactive.
package gdc_pkg;

   // ************************************************************
   // Timing.
   // ************************************************************
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned TICK_S = 1;
   localparam int unsigned SECOND_CYCLES = CLK_HZ * TICK_S;
   localparam int unsigned FILTER_US = 100;
   localparam int unsigned FILTER_CYCLES = CLK_HZ / 1_000_000 * FILTER_US;
   localparam logic [9:0] SECONDS_PER_MINUTE = 10'h03C;

   // ************************************************************
   // Register offsets (byte addresses).
   // ************************************************************
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0C;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;

   // ************************************************************
   // Field positions and reset values.
   // ************************************************************
   localparam int unsigned CTRL_FIL_BIT = 0;
   localparam int unsigned CTRL_EMI_BIT = 1;
   localparam int unsigned CTRL_DSTART_BIT = 2;
   localparam int unsigned CTRL_DSTOP_BIT = 3;
   localparam int unsigned CTRL_MIN_LSB = 8;
   localparam int unsigned STAT_FIL_BIT = 0;
   localparam int unsigned STAT_DEG_BIT = 1;
   localparam int unsigned STAT_EMI_BIT = 2;
   localparam int unsigned STAT_PIN_LSB = 4;
   localparam int unsigned STAT_LEFT_LSB = 16;
   localparam int unsigned IRQ_FIL_BIT = 0;
   localparam int unsigned IRQ_DSTART_BIT = 1;
   localparam int unsigned IRQ_DDONE_BIT = 2;
   localparam logic [3:0] DEGAS_MIN_LO = 4'h2;
   localparam logic [3:0] DEGAS_MIN_HI = 4'hA;
   localparam logic [3:0] DEGAS_MIN_RST = 4'h2;
   localparam logic [2:0] IRQ_ENABLE_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Input index of each discrete source.
   localparam int unsigned IN_SENSOR = 0;
   localparam int unsigned IN_DEGAS = 1;
   localparam int unsigned IN_EMISSION = 2;
   localparam int unsigned IN_BTN_FIL = 3;
   localparam int unsigned IN_BTN_EMI = 4;
   localparam int unsigned IN_BTN_DEG = 5;
   localparam int unsigned IN_COUNT = 6;

endpackage : gdc_pkg

/* hdl/gdc_input_filter.sv */
// Synchroniser and glitch filter for one ground-active contact input.
`timescale 1ns/100ps
module gdc_input_filter (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic pin_n,
   output logic grounded,
   output logic groundEdge,
   output logic releaseEdge
);

   typedef struct packed {
      logic [2:0] sync;
      logic [11:0] count;
      logic level;
      logic fall;
      logic rise;
   } gdc_filt_t;

   gdc_filt_t s;
   gdc_filt_t next_s;

   // ************************************************************
   // Filter logic.
   // ************************************************************
   // A change is seen only when the second and third stages agree, and it must then hold
   // for the whole filter time; a contact bounce restarts the wait.
   always_comb begin
      next_s = s;
      next_s.sync = {s.sync[1:0], pin_n};
      next_s.fall = 1'b0;
      next_s.rise = 1'b0;
      if (s.sync[2] == s.sync[1] && s.sync[2] != s.level) begin
         if (s.count == 12'(gdc_pkg::FILTER_CYCLES - 1)) begin // R10
            next_s.level = s.sync[2];
            next_s.count = 12'h000;
            next_s.fall = ~s.sync[2];
            next_s.rise = s.sync[2];
         end else begin
            next_s.count = s.count + 12'h001;
         end
      end else begin
         next_s.count = 12'h000;
      end
   end

   // Open contacts read high, so the filter starts in the released state.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{sync: 3'h7, count: 12'h000, level: 1'b1, fall: 1'b0, rise: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign grounded = ~s.level;
   assign groundEdge = s.fall;
   assign releaseEdge = s.rise;

endmodule : gdc_input_filter

/* sim/gdc_contacts.sv */
// Behavioural process controller that grounds the gauge contact inputs.
`timescale 1ns/100ps
module gdc_contacts (
   input wire logic [2:0] groundReq,
   input wire logic glitch,
   output logic sensorOnPin_n,
   output logic degasPin_n,
   output logic emissionPin_n
);
   // Open contacts are pulled up, so an open contact reads high except while glitch grounds the degas pin.
   // The glitch input gives a short false ground that the filter must reject.
   assign sensorOnPin_n = ~groundReq[0];
   assign degasPin_n = ~(groundReq[1] | glitch);
   assign emissionPin_n = ~groundReq[2];
endmodule : gdc_contacts

/* sim/gdc_control_monitor.sv */
// Port checker for the gauge discrete control block.
`timescale 1ns/100ps
module gdc_control_monitor #(
   parameter int unsigned SECOND_CYCLES = gdc_pkg::SECOND_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sensorOnPin_n,
   input wire logic emissionPin_n,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [31:0] wdata,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic filamentOn,
   input wire logic emission4mA,
   input wire logic degasOn,
   input wire logic degasStatusOc,
   input wire logic filamentStatusOc
);
   // The settle margin sits above the filter delay to allow for synchroniser slack.
   localparam int SETTLE = 2050;
   // Wide bounds, since a real-rate second makes a ten-minute run overflow 32 bits.
   localparam longint MIN_RUN = 120 * longint'(SECOND_CYCLES) - 2;
   localparam longint MAX_RUN = 600 * longint'(SECOND_CYCLES) + 2;
   logic [11:0] senLow;
   logic [11:0] emiLow;
   longint runLen;
   logic stopSeen;
   // Hold counters saturate, so a long ground never wraps back to a short one.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         senLow <= 12'h000;
         emiLow <= 12'h000;
         runLen <= 0;
         stopSeen <= 1'b0;
      end else begin
         senLow <= sensorOnPin_n ? 12'h000 : senLow + 12'(senLow != 12'hFFF);
         emiLow <= emissionPin_n ? 12'h000 : emiLow + 12'(emiLow != 12'hFFF);
         runLen <= degasOn ? runLen + 1 : 0;
         stopSeen <= degasOn & (stopSeen | (wvalid & wready & wdata[gdc_pkg::CTRL_DSTOP_BIT]));
      end
   end
   default clocking monClk @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   property p_degas_oc; degasStatusOc == degasOn; endproperty
   a_degas_oc: assert property (p_degas_oc)
      else $error("degas status output wrong");
   property p_fil_oc; filamentStatusOc == filamentOn; endproperty
   a_fil_oc: assert property (p_fil_oc)
      else $error("filament status output wrong");
   property p_wr_answer; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write response late");
   property p_b_stands; bvalid && !bready |=> bvalid; endproperty
   a_b_stands: assert property (p_b_stands)
      else $error("write response dropped");
   property p_r_stands; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_stands: assert property (p_r_stands)
      else $error("read data dropped");
   property p_sensor_on; senLow >= SETTLE |-> filamentOn; endproperty
   a_sensor_on: assert property (p_sensor_on)
      else $error("filament off while sensor grounded");
   property p_emi_on; emiLow >= SETTLE |-> emission4mA; endproperty
   a_emi_on: assert property (p_emi_on)
      else $error("low emission while grounded");
   property p_degas_len;
      $fell(degasOn) |-> stopSeen || (runLen >= MIN_RUN && runLen <= MAX_RUN);
   endproperty
   a_degas_len: assert property (p_degas_len)
      else $error("degas run length wrong");
endmodule : gdc_control_monitor
bind gdc_control gdc_control_monitor #(.SECOND_CYCLES(SECOND_CYCLES)) mon (
   .clock, .rst_n, .sensorOnPin_n, .emissionPin_n, .awvalid, .awready, .wvalid,
   .wready, .wdata, .bvalid, .bready, .rvalid, .rready, .rdata, .filamentOn,
   .emission4mA, .degasOn, .degasStatusOc, .filamentStatusOc);

/* sim/gdc_control_tb.sv */
// Self-checking testbench for the gauge discrete control block.
`timescale 1ns/100ps
module gdc_control_tb;
   // A short second keeps each degas run to a few thousand cycles.
   localparam int SC = 10;
   localparam logic [7:0] CTRL = gdc_pkg::OFS_CONTROL;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] groundReq = 3'h0;
   logic [2:0] btn_n = 3'h7;
   logic glitch = 1'b0;
   logic sensorOnPin_n, degasPin_n, emissionPin_n;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata, d;
   logic [1:0] bresp, rresp, r;
   logic filamentOn, emission4mA, degasOn, degasStatusOc, filamentStatusOc, irq;
   int n_mismatch = 0;
   int checks_done = 0;
   int cycleCount = 0;
   int n;
   // Rows: sensor grounded, emission grounded, expected filament, expected 4 mA.
   logic [3:0] rows [4] = '{4'b1010, 4'b1111, 4'b0101, 4'b0000};
   always #25 clock = ~clock;
   gdc_contacts ctl (.groundReq, .glitch, .sensorOnPin_n, .degasPin_n, .emissionPin_n);
   gdc_control #(.SECOND_CYCLES(SC)) dut (
      .clock, .rst_n, .sensorOnPin_n, .degasPin_n, .emissionPin_n,
      .panelFilamentBtn_n(btn_n[0]), .panelEmissionBtn_n(btn_n[1]),
      .panelDegasBtn_n(btn_n[2]), .awvalid, .awready, .awaddr, .awprot(3'h0),
      .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
      .filamentOn, .emission4mA, .degasOn, .degasStatusOc, .filamentStatusOc, .irq);
   // ************************************************************
   // Tasks.
   // ************************************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cycles(input int k);
      repeat (k) @(posedge clock);
   endtask : cycles
   // Each channel is released only at the edge where its ready was seen high.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input int lag = 0);
      @(posedge clock);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= (lag == 0);
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      // A late bready leaves the response waiting, so the slave must keep it standing.
      if (lag > 0) begin
         cycles(lag);
         bready <= 1'b1;
         @(posedge clock);
      end
      bready <= 1'b0;
      r = bresp;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input int lag = 0);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= (lag == 0);
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      // A late rready checks that the read data stays put while it waits.
      if (lag > 0) begin
         cycles(lag);
         rready <= 1'b1;
         @(posedge clock);
      end
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask : axi_rd
   // A press outlasts the glitch filter, then the button is left open as long.
   task automatic press(input int i);
      btn_n[i] <= 1'b0;
      cycles(2100);
      btn_n[i] <= 1'b1;
      cycles(2100);
   endtask : press
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict
   // The full sequence needs about 48500 cycles; a hang stops well after that.
   always @(posedge clock) begin
      cycleCount++;
      if (cycleCount == 90000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial begin
      cycles(16);
      rst_n <= 1'b1;
      chk("filamentOn", 0, 32'(filamentOn));
      foreach (rows[i]) begin
         groundReq <= {rows[i][2], 1'b0, rows[i][3]};
         cycles(2100);
         chk("filamentOn", 32'(rows[i][1]), 32'(filamentOn));
         chk("filamentStatusOc", 32'(rows[i][1]), 32'(filamentStatusOc));
         chk("emission4mA", 32'(rows[i][0]), 32'(emission4mA));
      end
      groundReq <= 3'b001;
      rst_n <= 1'b0;
      cycles(2100);
      rst_n <= 1'b1;
      cycles(2);
      chk("filamentOn", 0, 32'(filamentOn));
      cycles(2100);
      chk("filamentOn", 1, 32'(filamentOn));
      groundReq <= 3'b000;
      cycles(2100);
      chk("filamentOn", 0, 32'(filamentOn));
      glitch <= 1'b1;
      cycles(10);
      glitch <= 1'b0;
      cycles(100);
      chk("degasOn", 0, 32'(degasOn));
      cycles(2000);
      axi_wr(CTRL, 32'h0000_0F00);
      axi_rd(CTRL);
      chk("control", 32'h0000_0A00, d);
      groundReq <= 3'b010;
      n = 0;
      while (degasOn !== 1'b1 && n < 2200) begin
         @(posedge clock);
         n++;
      end
      chk("degasStatusOc", 1, 32'(degasStatusOc));
      n = 0;
      while (degasOn === 1'b1) begin
         @(posedge clock);
         n++;
      end
      chk("degasRunOk", 1, 32'(n >= 600 * SC - 1 && n <= 600 * SC + 1));
      cycles(500);
      chk("degasOn", 0, 32'(degasOn));
      groundReq <= 3'b000;
      cycles(2100);
      groundReq <= 3'b010;
      cycles(2100);
      groundReq <= 3'b000;
      chk("degasOn", 1, 32'(degasOn));
      cycles(2100);
      chk("degasOn", 1, 32'(degasOn));
      axi_wr(CTRL, 32'h0000_0A08);
      cycles(3);
      chk("degasOn", 0, 32'(degasOn));
      axi_wr(CTRL, 32'h0000_0A01);
      cycles(2);
      chk("filamentOn", 1, 32'(filamentOn));
      axi_rd(gdc_pkg::OFS_STATUS);
      chk("statusFil", 1, 32'(d[0]));
      axi_wr(CTRL, 32'h0000_0A00);
      press(0);
      chk("filamentOn", 1, 32'(filamentOn));
      press(0);
      chk("filamentOn", 0, 32'(filamentOn));
      press(1);
      chk("emission4mA", 1, 32'(emission4mA));
      press(2);
      chk("degasOn", 1, 32'(degasOn));
      axi_wr(CTRL, 32'h0000_0A08);
      axi_wr(gdc_pkg::OFS_IRQ_ENABLE, 32'h0000_0000, 3);
      cycles(2);
      chk("irq", 0, 32'(irq));
      axi_wr(gdc_pkg::OFS_IRQ_ENABLE, 32'h0000_0007);
      cycles(2);
      chk("irq", 1, 32'(irq));
      axi_wr(gdc_pkg::OFS_IRQ_CLEAR, 32'h0000_0007);
      chk("bresp", 32'(gdc_pkg::RESP_OKAY), 32'(r));
      cycles(2);
      chk("irq", 0, 32'(irq));
      axi_rd(gdc_pkg::OFS_IRQ_STATUS, 3);
      chk("irqStatus", 0, d);
      axi_wr(8'h20, 32'h0000_0000);
      chk("bresp", 32'(gdc_pkg::RESP_SLVERR), 32'(r));
      axi_rd(8'h20);
      chk("rresp", 32'(gdc_pkg::RESP_SLVERR), 32'(r));
      chk("rdata", 0, d);
      axi_rd(gdc_pkg::OFS_IRQ_CLEAR);
      chk("rresp", 32'(gdc_pkg::RESP_SLVERR), 32'(r));
      print_verdict();
   end
endmodule : gdc_control_tb
